// *** src/cac_pkg.sv ***
// Package for the calendar alarm clock register block.
// Assumes a 40 MHz core clock and a 32.768 kHz crystal level on a pin.
`default_nettype none

package cac_pkg;

    // APB address and data widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // Register offsets
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_STS    = 8'h04;
    localparam logic [7:0] OFS_TIME   = 8'h08;
    localparam logic [7:0] OFS_DATE   = 8'h0c;
    localparam logic [7:0] OFS_TALARM = 8'h10;
    localparam logic [7:0] OFS_DALARM = 8'h14;

    // Control and status field positions
    localparam int CTRL_RUN_BIT    = 0;
    localparam int CTRL_UNLOCK_BIT = 1;
    localparam int CTRL_IRQEN_BIT  = 2;
    localparam int CTRL_WAKEEN_BIT = 3;
    localparam int CTRL_CLR_BIT    = 4;
    localparam int CTRL_TRIG_BIT   = 5;
    localparam int CTRL_POL_BIT    = 6;
    localparam int CTRL_W          = 7;
    localparam int STS_FLAG_BIT    = 0;

    // Reset values and writable masks
    localparam logic [6:0]  CTRL_RST    = 7'h00;
    localparam logic [31:0] TIME_RST    = 32'h0000_0000;
    localparam logic [31:0] DATE_RST    = 32'h1000_0100;
    localparam logic [31:0] TALARM_RST  = 32'h0000_0000;
    localparam logic [31:0] DALARM_RST  = 32'h1000_0000;
    localparam logic [31:0] TIME_MASK   = 32'h003f_7f7f;
    localparam logic [31:0] DATE_MASK   = 32'h7fff_ff3f;

    // Rollover limits in BCD; month limits in binary
    localparam logic [7:0] LAST_SEC  = 8'h59;
    localparam logic [7:0] LAST_MIN  = 8'h59;
    localparam logic [7:0] LAST_HOUR = 8'h23;
    localparam logic [7:0] LAST_YEAR = 8'h99;
    localparam logic [7:0] FIRST_ZERO = 8'h00;
    localparam logic [7:0] FIRST_DAY  = 8'h01;
    localparam logic [3:0] MON_FIRST  = 4'h1;
    localparam logic [3:0] MON_LAST   = 4'hc;
    localparam logic [2:0] WK_FIRST   = 3'h1;
    localparam logic [2:0] WK_LAST    = 3'h7;

    // Crystal edges per second
    localparam int XTAL_HZ = 32768;
    localparam int DIV_W   = 15;

    // Control register fields, bit 6 down to bit 0
    typedef struct packed {
        logic pol;
        logic trig;
        logic clr;
        logic wake_en;
        logic irq_en;
        logic unlock;
        logic run;
    } cac_ctrl_t;

    // Time word layout
    typedef struct packed {
        logic [9:0] rsv_a;
        logic [1:0] hr_t;
        logic [3:0] hr_u;
        logic       rsv_b;
        logic [2:0] mn_t;
        logic [3:0] mn_u;
        logic       rsv_c;
        logic [2:0] sc_t;
        logic [3:0] sc_u;
    } cac_time_t;

    // Date word layout
    typedef struct packed {
        logic       rsv_a;
        logic [2:0] wk;
        logic [3:0] cen_t;
        logic [3:0] cen_u;
        logic [3:0] yr_t;
        logic [3:0] yr_u;
        logic [3:0] mon;
        logic [1:0] rsv_b;
        logic [1:0] day_t;
        logic [3:0] day_u;
    } cac_date_t;

endpackage

`default_nettype wire

// *** src/cac_sync2.sv ***
// Two flip-flop synchroniser for one level.
// Assumes the input is asynchronous to i_core_clk.
`default_nettype none

module cac_sync2 (
    // Clock and reset
    input  wire logic i_core_clk,
    input  wire logic i_reset,
    // Level in and out
    input  wire logic i_d,
    output logic      o_q
);

    logic meta_ff;
    logic sync_ff;

    // First stage feeds only the second
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
        end else begin
            meta_ff <= i_d;
            sync_ff <= meta_ff;
        end
    end

    assign o_q = sync_ff;

endmodule

`default_nettype wire

// *** src/cac_bcd_step.sv ***
// One step of a two-digit BCD counter with a wrap limit.
// Assumes the caller applies the step only on its carry-in.
`default_nettype none

module cac_bcd_step (
    // Current value and limits
    input  wire logic [7:0] i_val,
    input  wire logic [7:0] i_last,
    input  wire logic [7:0] i_first,
    // Stepped value and carry-out
    output logic [7:0]      o_next,
    output logic            o_wrap
);

    // Out-of-range values wrap as well
    always_comb begin
        o_wrap = (i_val >= i_last);
        if (o_wrap) begin
            o_next = i_first;
        end else if (i_val[3:0] >= 4'h9) begin
            o_next = {i_val[7:4] + 4'h1, 4'h0};
        end else begin
            o_next = {i_val[7:4], i_val[3:0] + 4'h1};
        end
    end

endmodule

`default_nettype wire

// *** src/cac_regs.sv ***
// Calendar clock with alarm, APB slave register block.
// Assumes a 40 MHz core clock and a free crystal level on i_xtal_32k.
// Notes on behaviour
// - Wake polarity bit 6: 0 asserts wake high, 1 asserts it low.
// - Trigger select: 0 makes interrupt a level, 1 a pulse.
// - Wake output follows alarm only while wake enable bit 3 is set.
// - Interrupt output reaches system only while interrupt enable is set.
// - Calendar advances only while run is 1, else it holds.
// - Alarm flag bit 0 set by hardware, cleared by writing 1.
// - Date weekday in 30:28, values 1 to 7, resets 1; bit 31 reserved.
// - Date century tens in 27:24, decimal digit, resets 0.
// - Date century units in 23:20, decimal digit, resets 0.
// - Year tens 19:16 and year units 15:12, decimal digits, reset 0.
// - Month in 11:8, values 1 to 12, resets 1.
// - Day tens in 5:4, values 0 to 3; bits 7:6 reserved.
// - Day units in 3:0 of date and date alarm, resets 0.
// - Time alarm hour tens 21:20, hour units 19:16; 31:22 reserved.
// - Time alarm minute tens 14:12, minute units 11:8; bit 15 reserved.
// - Time alarm second tens 6:4, second units 3:0; bit 7 reserved.
// - Date alarm mirrors date; month resets 0, weekday resets 1.
// - Alarm fires when calendar equals both alarm registers.
`default_nettype none

module cac_regs #(
    parameter int P_XTAL_DIV = cac_pkg::XTAL_HZ
) (
    // Clock and reset
    input  wire logic                       i_core_clk,
    input  wire logic                       i_reset,
    // APB slave
    input  wire logic                       i_psel,
    input  wire logic                       i_penable,
    input  wire logic                       i_pwrite,
    input  wire logic [cac_pkg::ADDR_W-1:0] i_paddr,
    input  wire logic [cac_pkg::DATA_W-1:0] i_pwdata,
    output logic      [cac_pkg::DATA_W-1:0] o_prdata,
    output logic                            o_pready,
    output logic                            o_pslverr,
    // Crystal pin
    input  wire logic                       i_xtal_32k,
    // Alarm outputs
    output logic                            o_alarm_irq,
    output logic                            o_wake
);
    import cac_pkg::*;

    logic                xtal_s;
    logic                xtal_d_ff;
    logic [DIV_W-1:0]    div_ff;
    logic [DIV_W-1:0]    nxt_div;
    logic                tick_ff;
    logic                nxt_tick;
    cac_ctrl_t           ctrl_ff;
    cac_ctrl_t           nxt_ctrl;
    cac_time_t           time_ff;
    cac_time_t           nxt_time;
    cac_date_t           date_ff;
    cac_date_t           nxt_date;
    logic [31:0]         talarm_ff;
    logic [31:0]         nxt_talarm;
    logic [31:0]         dalarm_ff;
    logic [31:0]         nxt_dalarm;
    logic                flag_ff;
    logic                nxt_flag;
    logic                match_d_ff;
    logic                irq_ff;
    logic                nxt_irq;
    logic                wake_ff;
    logic                nxt_wake;
    logic [31:0]         prdata_ff;
    logic [31:0]         nxt_prdata;
    logic                wr_en;
    logic                wr_ok;
    logic                wr_ctrl;
    logic                wr_sts;
    logic                wr_time;
    logic                wr_date;
    logic                mapped;
    logic                clr_pulse;
    logic                adv;
    logic                match;
    logic                fire;
    logic                leap;
    logic                mon_en;
    logic                mon_wrap;
    logic [7:0]          cur  [6];
    logic [7:0]          lim  [6];
    logic [7:0]          fst  [6];
    logic [7:0]          stp  [6];
    logic [7:0]          upd  [6];
    logic                wrp  [6];
    logic                en   [6];

    // Crystal pin resynchronised before use
    cac_sync2 u_xtal_sync (
        .i_core_clk (i_core_clk),
        .i_reset    (i_reset),
        .i_d        (i_xtal_32k),
        .o_q        (xtal_s)
    );

    // APB decode
    always_comb begin
        wr_en   = i_psel & i_penable & i_pwrite;
        wr_ctrl = wr_en & (i_paddr == OFS_CTRL);
        wr_sts  = wr_en & (i_paddr == OFS_STS);
        wr_time = wr_en & (i_paddr == OFS_TIME);
        wr_date = wr_en & (i_paddr == OFS_DATE);
        mapped  = (i_paddr == OFS_CTRL) | (i_paddr == OFS_STS)
                | (i_paddr == OFS_TIME) | (i_paddr == OFS_DATE)
                | (i_paddr == OFS_TALARM) | (i_paddr == OFS_DALARM);
        wr_ok     = ~ctrl_ff.run & ctrl_ff.unlock;
        clr_pulse = wr_ctrl & i_pwdata[CTRL_CLR_BIT];
    end

    // Zero-wait slave, error on unmapped access
    assign o_pready  = 1'b1;
    assign o_pslverr = i_psel & i_penable & ~mapped;

    // Divider from crystal edges to a one second tick
    always_comb begin
        nxt_div  = div_ff;
        nxt_tick = 1'b0;
        if (clr_pulse) begin
            nxt_div = '0;
        end else if (xtal_s & ~xtal_d_ff) begin
            if (div_ff == DIV_W'(P_XTAL_DIV - 1)) begin
                nxt_div  = '0;
                nxt_tick = 1'b1;
            end else begin
                nxt_div = div_ff + 1'b1;
            end
        end
    end

    // Leap years by year digits; month end in BCD
    always_comb begin
        leap = date_ff.yr_t[0] ? (date_ff.yr_u == 4'h2 || date_ff.yr_u == 4'h6)
                               : (date_ff.yr_u == 4'h0 || date_ff.yr_u == 4'h4
                                  || date_ff.yr_u == 4'h8);
        cur[0] = {1'b0, time_ff.sc_t, time_ff.sc_u};
        cur[1] = {1'b0, time_ff.mn_t, time_ff.mn_u};
        cur[2] = {2'b00, time_ff.hr_t, time_ff.hr_u};
        cur[3] = {2'b00, date_ff.day_t, date_ff.day_u};
        cur[4] = {date_ff.yr_t, date_ff.yr_u};
        cur[5] = {date_ff.cen_t, date_ff.cen_u};
        lim[0] = LAST_SEC;
        lim[1] = LAST_MIN;
        lim[2] = LAST_HOUR;
        unique case (date_ff.mon)
            4'h2:                      lim[3] = leap ? 8'h29 : 8'h28;
            4'h4, 4'h6, 4'h9, 4'hb:    lim[3] = 8'h30;
            default:                   lim[3] = 8'h31;
        endcase
        lim[4] = LAST_YEAR;
        lim[5] = LAST_YEAR;
        fst[0] = FIRST_ZERO;
        fst[1] = FIRST_ZERO;
        fst[2] = FIRST_ZERO;
        fst[3] = FIRST_DAY;
        fst[4] = FIRST_ZERO;
        fst[5] = FIRST_ZERO;
    end

    // One BCD stepper per two-digit field
    for (genvar g = 0; g < 6; g++) begin : g_step
        cac_bcd_step u_step (
            .i_val   (cur[g]),
            .i_last  (lim[g]),
            .i_first (fst[g]),
            .o_next  (stp[g]),
            .o_wrap  (wrp[g])
        );
    end

    // Carry chain through seconds up to centuries
    always_comb begin
        adv      = tick_ff & ctrl_ff.run;
        en[0]    = adv;
        en[1]    = en[0] & wrp[0];
        en[2]    = en[1] & wrp[1];
        en[3]    = en[2] & wrp[2];
        mon_wrap = (date_ff.mon >= MON_LAST);
        mon_en   = en[3] & wrp[3];
        en[4]    = mon_en & mon_wrap;
        en[5]    = en[4] & wrp[4];
        for (int i = 0; i < 6; i++) begin
            upd[i] = en[i] ? stp[i] : cur[i];
        end
    end

    // Calendar next value: clear, unlocked write, or advance
    always_comb begin
        nxt_time = time_ff;
        nxt_date = date_ff;
        if (clr_pulse) begin
            nxt_time = cac_time_t'(TIME_RST);
            nxt_date = cac_date_t'(DATE_RST);
        end else if (wr_time & wr_ok) begin
            nxt_time = cac_time_t'(i_pwdata & TIME_MASK);
        end else if (wr_date & wr_ok) begin
            nxt_date = cac_date_t'(i_pwdata & DATE_MASK);
        end else if (adv) begin
            {nxt_time.sc_t, nxt_time.sc_u} = upd[0][6:0];
            {nxt_time.mn_t, nxt_time.mn_u} = upd[1][6:0];
            {nxt_time.hr_t, nxt_time.hr_u} = upd[2][5:0];
            {nxt_date.day_t, nxt_date.day_u} = upd[3][5:0];
            {nxt_date.yr_t, nxt_date.yr_u} = upd[4];
            {nxt_date.cen_t, nxt_date.cen_u} = upd[5];
            if (mon_en) begin
                nxt_date.mon = mon_wrap ? MON_FIRST : date_ff.mon + 4'h1;
            end
            if (en[3]) begin
                nxt_date.wk = (date_ff.wk >= WK_LAST) ? WK_FIRST : date_ff.wk + 3'h1;
            end
        end
    end

    // Control and alarm comparands
    always_comb begin
        nxt_ctrl   = ctrl_ff;
        nxt_talarm = talarm_ff;
        nxt_dalarm = dalarm_ff;
        if (wr_ctrl) begin
            nxt_ctrl     = cac_ctrl_t'(i_pwdata[CTRL_W-1:0]);
            nxt_ctrl.clr = 1'b0;
        end
        if (wr_en & (i_paddr == OFS_TALARM)) begin
            nxt_talarm = i_pwdata & TIME_MASK;
        end
        if (wr_en & (i_paddr == OFS_DALARM)) begin
            nxt_dalarm = i_pwdata & DATE_MASK;
        end
    end

    // Alarm match, sticky flag and output pins
    always_comb begin
        match = (time_ff == cac_time_t'(talarm_ff))
              & (date_ff == cac_date_t'(dalarm_ff));
        fire  = match & ~match_d_ff;
        nxt_flag = fire | (flag_ff & ~(wr_sts & i_pwdata[STS_FLAG_BIT]));
        nxt_irq  = ctrl_ff.irq_en
                 & (ctrl_ff.trig ? fire : nxt_flag);
        nxt_wake = ctrl_ff.pol
                 ^ (ctrl_ff.wake_en & nxt_flag);
    end

    // Read data captured in the setup phase
    always_comb begin
        nxt_prdata = prdata_ff;
        if (i_psel & ~i_penable & ~i_pwrite) begin
            unique case (i_paddr)
                OFS_CTRL:   nxt_prdata = {25'h0, ctrl_ff.pol, ctrl_ff.trig, 1'b0,
                                          ctrl_ff.wake_en, ctrl_ff.irq_en,
                                          ctrl_ff.unlock, ctrl_ff.run};
                OFS_STS:    nxt_prdata = {31'h0, flag_ff};
                OFS_TIME:   nxt_prdata = time_ff;
                OFS_DATE:   nxt_prdata = date_ff;
                OFS_TALARM: nxt_prdata = talarm_ff;
                OFS_DALARM: nxt_prdata = dalarm_ff;
                default:    nxt_prdata = 32'h0000_0000;
            endcase
        end
    end

    // State registers
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            xtal_d_ff  <= 1'b0;
            div_ff     <= '0;
            tick_ff    <= 1'b0;
            ctrl_ff    <= cac_ctrl_t'(CTRL_RST);
            time_ff    <= cac_time_t'(TIME_RST);
            date_ff    <= cac_date_t'(DATE_RST);
            talarm_ff  <= TALARM_RST;
            dalarm_ff  <= DALARM_RST;
            flag_ff    <= 1'b0;
            match_d_ff <= 1'b0;
            irq_ff     <= 1'b0;
            wake_ff    <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
        end else begin
            xtal_d_ff  <= xtal_s;
            div_ff     <= nxt_div;
            tick_ff    <= nxt_tick;
            ctrl_ff    <= nxt_ctrl;
            time_ff    <= nxt_time;
            date_ff    <= nxt_date;
            talarm_ff  <= nxt_talarm;
            dalarm_ff  <= nxt_dalarm;
            flag_ff    <= nxt_flag;
            match_d_ff <= match;
            irq_ff     <= nxt_irq;
            wake_ff    <= nxt_wake;
            prdata_ff  <= nxt_prdata;
        end
    end

    assign o_prdata    = prdata_ff;
    assign o_alarm_irq = irq_ff;
    assign o_wake      = wake_ff;

    // Checks on the alarm path and calendar
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_reset);

    a_wake_high_pol: assert property (
        flag_ff && ctrl_ff.wake_en && !ctrl_ff.pol && $stable(ctrl_ff) |-> o_wake)
        else $error("wake not high for high polarity");
    a_wake_low_pol: assert property (
        flag_ff && ctrl_ff.wake_en && ctrl_ff.pol && $stable(ctrl_ff) |-> !o_wake)
        else $error("wake not low for low polarity");
    a_irq_level_mode: assert property (
        !ctrl_ff.trig && ctrl_ff.irq_en && $stable(ctrl_ff) |-> o_alarm_irq == flag_ff)
        else $error("level interrupt does not follow flag");
    a_irq_edge_pulse: assert property (
        ctrl_ff.trig && $stable(ctrl_ff) && o_alarm_irq |=> !o_alarm_irq)
        else $error("edge interrupt longer than one cycle");
    a_wake_disabled: assert property (
        !ctrl_ff.wake_en |=> o_wake == $past(ctrl_ff.pol))
        else $error("wake asserted while disabled");
    a_irq_masked: assert property (
        !ctrl_ff.irq_en |=> !o_alarm_irq)
        else $error("interrupt while masked");
    a_halt_holds: assert property (
        !ctrl_ff.run && !clr_pulse && !wr_time |=> $stable(time_ff))
        else $error("time moved while halted");
    a_locked_write: assert property (
        wr_date && !wr_ok && !clr_pulse && !adv |=> $stable(date_ff))
        else $error("date written while locked");
    a_flag_set_wins: assert property (
        fire |=> flag_ff ##1 flag_ff || $past(wr_sts) || wr_sts)
        else $error("alarm flag lost");
    a_flag_clear: assert property (
        flag_ff && !fire && wr_sts && i_pwdata[0] |=> !flag_ff)
        else $error("flag not cleared by write one");
    a_date_reserved: assert property (
        date_ff.rsv_a == 1'b0 && date_ff.rsv_b == 2'b00)
        else $error("reserved date bits set");
    a_match_fires: assert property (
        match && !match_d_ff |=> flag_ff)
        else $error("match did not set flag");
    a_clear_resets: assert property (
        clr_pulse |=> div_ff == '0 && time_ff == TIME_RST && !ctrl_ff.clr)
        else $error("counter clear incomplete");
    a_sec_wrap: assert property (
        adv && cur[0] == LAST_SEC |=> time_ff.sc_t == 3'h0 && time_ff.sc_u == 4'h0)
        else $error("seconds did not wrap");

    c_alarm_fire:  cover property (fire && ctrl_ff.irq_en);
    c_flag_clear:  cover property (flag_ff ##1 !flag_ff);
    c_day_roll:    cover property (en[3] && wrp[3]);
    c_edge_irq:    cover property (ctrl_ff.trig && o_alarm_irq);

endmodule

`default_nettype wire

// *** verification/cac_apb_master.sv ***
// APB master model standing in for the host processor.
// Assumes the bench calls xfer from one process only.
`default_nettype none

module cac_apb_master (
    // Clock
    input  wire logic        i_core_clk,
    // APB request side
    output logic             o_psel,
    output logic             o_penable,
    output logic             o_pwrite,
    output logic [7:0]       o_paddr,
    output logic [31:0]      o_pwdata,
    // APB answer side
    input  wire logic [31:0] i_prdata,
    input  wire logic        i_pready,
    input  wire logic        i_pslverr
);
    timeunit 1ns;
    timeprecision 100ps;

    // Bus idle from time zero
    initial begin
        o_psel    = 1'b0;
        o_penable = 1'b0;
        o_pwrite  = 1'b0;
        o_paddr   = 8'h00;
        o_pwdata  = 32'h0;
    end

    // Setup, access held until ready, then release with scrambled lines
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e, output logic to);
        @(negedge i_core_clk);
        o_psel    = 1'b1;
        o_penable = 1'b0;
        o_pwrite  = w;
        o_paddr   = a;
        o_pwdata  = d;
        @(negedge i_core_clk);
        o_penable = 1'b1;
        to        = 1'b1;
        for (int i = 0; i < 16 && to; i++) begin
            @(posedge i_core_clk);
            if (i_pready === 1'b1) begin
                q  = i_prdata;
                e  = i_pslverr;
                to = 1'b0;
            end
        end
        @(negedge i_core_clk);
        o_psel    = 1'b0;
        o_penable = 1'b0;
        o_paddr   = ~a;
        o_pwdata  = ~d;
    endtask
endmodule

`default_nettype wire

// *** verification/cac_regs_tb_top.sv ***
// Self-checking bench for the calendar alarm clock registers.
// Assumes cac_regs and cac_apb_master are compiled before it.
`default_nettype none

module cac_regs_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import cac_pkg::*;

    logic        clk, rst, psel, pen, pwr, pslverr, pready, xtal, irq, wake, err, to;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd, d;
    logic [6:0]  c;
    int          error_cnt, cmp_count, irq_cnt;
    logic [31:0] rstv [6] = '{32'h0, 32'h0, 32'h0, 32'h1000_0100, 32'h0, 32'h1000_0000};

    // Core clock, free crystal, edge interrupt counter
    initial clk = 1'b0;
    initial xtal = 1'b0;
    always #12.5 clk = ~clk;
    always #61 xtal = ~xtal;
    always @(negedge clk) if (irq === 1'b1) irq_cnt <= irq_cnt + 1;

    cac_regs #(.P_XTAL_DIV(4)) cac_regs_i (
        .i_core_clk(clk), .i_reset(rst), .i_psel(psel), .i_penable(pen),
        .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_xtal_32k(xtal),
        .o_alarm_irq(irq), .o_wake(wake));

    cac_apb_master cac_apb_master_i (
        .i_core_clk(clk), .o_psel(psel), .o_penable(pen), .o_pwrite(pwr),
        .o_paddr(paddr), .o_pwdata(pwdata), .i_prdata(prdata),
        .i_pready(pready), .i_pslverr(pslverr));

    // Wake level from flag, enable and polarity
    function automatic logic exp_wake(input logic [6:0] k, input logic fl);
        return (fl & k[3]) ^ k[6];
    endfunction

    // Counts and verdict
    task automatic give_verdict();
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic fail(input string m);
        error_cnt++;
        $display("unexpected at %0t: %s", $time, m);
    endtask

    // Word and pin comparisons
    task automatic chk32(input logic [31:0] g, input logic [31:0] x, input string m);
        cmp_count++;
        if (g !== x) fail($sformatf("%s got %h exp %h", m, g, x));
    endtask

    task automatic chk1(input logic g, input logic x, input string m);
        cmp_count++;
        if (g !== x) fail(m);
    endtask

    // One APB transfer, cut short if ready never comes
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
        cac_apb_master_i.xfer(w, a, v, rd, err, to);
        if (to) fail("no ready");
        if (to) give_verdict();
    endtask

    initial begin
        rst = 1'b1;
        void'($urandom(32'h78ddccff));
        repeat (3) @(negedge clk);
        rst = 1'b0;
        // Reset values, unmapped offset
        for (int i = 0; i < 6; i++) begin
            bus(1'b0, 8'(4 * i), 32'h0);
            chk32(rd, rstv[i], "reset value");
            chk1(err, 1'b0, "mapped error");
        end
        bus(1'b0, 8'h18, 32'h0);
        chk1(err, 1'b1, "unmapped error");
        chk32(rd, 32'h0, "unmapped read");
        $display("test reset done");
        // Locked write refused, unlocked random writes masked
        bus(1'b1, OFS_TIME, 32'h0012_3456);
        bus(1'b0, OFS_TIME, 32'h0);
        chk32(rd, 32'h0, "locked write");
        bus(1'b1, OFS_CTRL, 32'h2);
        repeat (4) begin
            d = $urandom;
            for (int i = 2; i < 6; i++) begin
                bus(1'b1, 8'(4 * i), d);
                bus(1'b0, 8'(4 * i), 32'h0);
                chk32(rd, d & ((i % 2) ? 32'h7fff_ff3f : 32'h003f_7f7f), "mask");
            end
        end
        $display("test fields done");
        // Counter clear self-clears and restores calendar
        bus(1'b1, OFS_CTRL, 32'h12);
        bus(1'b0, OFS_CTRL, 32'h0);
        chk32(rd, 32'h2, "clear bit");
        bus(1'b0, OFS_DATE, 32'h0);
        chk32(rd, 32'h1000_0100, "clear date");
        $display("test clear done");
        // Halt holds, run wraps day at month end
        bus(1'b1, OFS_DALARM, 32'h0);
        bus(1'b1, OFS_TIME, 32'h0023_5959);
        bus(1'b1, OFS_DATE, 32'h1000_0131);
        repeat (60) @(negedge clk);
        bus(1'b0, OFS_TIME, 32'h0);
        chk32(rd, 32'h0023_5959, "halted time");
        bus(1'b1, OFS_CTRL, 32'h1);
        for (int n = 0; n < 40 && rd === 32'h0023_5959; n++) bus(1'b0, OFS_TIME, 32'h0);
        chk32(rd, 32'h0, "time wrap");
        if (rd === 32'h0023_5959) give_verdict();
        bus(1'b0, OFS_DATE, 32'h0);
        chk32(rd, 32'h2000_0201, "date carry");
        $display("test rollover done");
        // Every enable, trigger and polarity combination
        bus(1'b1, OFS_CTRL, 32'h12);
        bus(1'b1, OFS_TALARM, 32'h0);
        for (int i = 0; i < 16; i++) begin
            c = {i[3:2], 1'b0, i[1:0], 2'b10};
            bus(1'b1, OFS_CTRL, {25'h0, c});
            bus(1'b1, OFS_DALARM, 32'h0);
            bus(1'b1, OFS_STS, 32'h1);
            irq_cnt = 0;
            bus(1'b1, OFS_DALARM, 32'h1000_0100);
            bus(1'b0, OFS_STS, 32'h0);
            chk32(rd, 32'h1, "alarm flag");
            chk1(wake, exp_wake(c, 1'b1), "wake active");
            chk1(irq, c[2] & ~c[5], "irq level");
            if (c[5]) chk32(irq_cnt, {31'h0, c[2]}, "irq pulse");
            bus(1'b1, OFS_STS, 32'h0);
            bus(1'b0, OFS_STS, 32'h0);
            chk32(rd, 32'h1, "zero write");
            bus(1'b1, OFS_STS, 32'h1);
            bus(1'b0, OFS_STS, 32'h0);
            chk32(rd, 32'h0, "flag clear");
            chk1(wake, exp_wake(c, 1'b0), "wake idle");
            chk1(irq, 1'b0, "irq idle");
        end
        $display("test alarm done");
        give_verdict();
    end
endmodule

`default_nettype wire
